//--- include/rsmc_params.svh
`ifndef RSMC_PARAMS_SVH
`define RSMC_PARAMS_SVH

// System clock period
`define RSMC_CLK_NS      10
// Longest times to reach TX or RX
`define RSMC_T_SHDN_NS   16800000
`define RSMC_T_SLOW_NS   800000
`define RSMC_T_FAST_NS   200000

// Register addresses
`define RSMC_A_STATUS    7'h02
`define RSMC_A_IEN2      7'h06
`define RSMC_A_MODE      7'h07

// Mode control register fields
`define RSMC_B_XTON      0
`define RSMC_B_PLLON     1
`define RSMC_B_RXON      2
`define RSMC_B_TXON      3
`define RSMC_B_ENLBD     5
`define RSMC_B_ENWT      6
`define RSMC_B_SWRES     7

// Reset values
`define RSMC_RST_MODE    8'h01
`define RSMC_RST_IEN2    8'h01
`define RSMC_RST_OTHER   8'h00

// Serial frame layout
`define RSMC_RW_BIT      7
`define RSMC_LAST_BIT    3'h7

`endif

//--- include/rsmc_pkg.sv
`default_nettype none

package rsmc_pkg;

	// Serial pins and shutdown pin sampled together
	typedef struct packed {
		logic sclk;
		logic sdi;
		logic chip_select_n;
		logic shutdown_pin;
	} rsmc_pins_t;

	typedef enum logic [2:0] {
		ST_SHUTDOWN = 3'b000,
		ST_POR      = 3'b001,
		ST_IDLE     = 3'b010,
		ST_GO_TX    = 3'b011,
		ST_TX       = 3'b100,
		ST_GO_RX    = 3'b101,
		ST_RX       = 3'b110
	} rsmc_state_t;

	typedef enum logic [1:0] {
		PRIM_SHUTDOWN = 2'b00,
		PRIM_IDLE     = 2'b01,
		PRIM_TX       = 2'b10,
		PRIM_RX       = 2'b11
	} rsmc_prim_t;

	typedef enum logic [2:0] {
		IDLE_STANDBY = 3'b000,
		IDLE_SLEEP   = 3'b001,
		IDLE_SENSOR  = 3'b010,
		IDLE_READY   = 3'b011,
		IDLE_TUNE    = 3'b100
	} rsmc_idle_t;

endpackage

`default_nettype wire

//--- core/rsmc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsmc_params.svh"

// Notes on behaviour
// - Frame is sixteen bits: select bit, seven address bits, eight data bits.
// - Seven address bits pick one of 128 byte registers.
// - Select bit one writes, zero reads.
// - A byte is captured every eight serial clocks.
// - Serial input is ignored during data bits of a read.
// - Read data shifts out on the eight falling edges after address.
// - After the last bit, serial output holds D0 until select rises.
// - With select high, serial output is released and pulled high.
// - Held select plus more clocks increments address, next register every byte.
// - Four states; shutdown from pin, others from mode register 07h.
// - Transmit or receive request from idle moves to TX or RX.
// - TX/RX reached within 16.8 ms, 800 us or 200 us by origin; from shutdown the code takes 16.8 ms plus the 200 us or 800 us idle start-up.
// - Shutdown pin high: shutdown, registers lost, no serial access.
// - Falling shutdown pin starts a power-on reset.
// - After reset, soft reset or shutdown exit, idle ready mode.
// - Writing zero to 07h gives standby; registers stay accessible.
// - Wake timer bit 40h selects sleep with wake timer running.
// - Low battery enable bit adds the detector in sensor mode.
// - Crystal hold bit selects ready mode, crystal kept running.
// - Synthesizer hold bit selects tune; crystal enabled automatically.
module rsmc_core #(
	parameter int P_SHDN_CYC = `RSMC_T_SHDN_NS / `RSMC_CLK_NS,
	parameter int P_SLOW_CYC = `RSMC_T_SLOW_NS / `RSMC_CLK_NS,
	parameter int P_FAST_CYC = `RSMC_T_FAST_NS / `RSMC_CLK_NS
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_clk_en,
	input  wire logic        i_sclk,
	input  wire logic        i_sdi,
	input  wire logic        i_chip_select_n,
	input  wire logic        i_shutdown_pin,
	output logic             o_sdo_out,
	output logic             o_sdo_oe_n,
	input  wire logic [6:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	output logic      [1:0]  o_radio_state,
	output logic      [2:0]  o_idle_mode,
	output logic             o_mode_busy,
	output logic             o_xtal_on,
	output logic             o_pll_on,
	output logic             o_wut_on,
	output logic             o_lbd_on,
	output logic             o_pa_on,
	output logic             o_rx_on
);

	rsmc_pkg::rsmc_pins_t  pin_s1_ff;
	rsmc_pkg::rsmc_pins_t  pin_s2_ff;
	rsmc_pkg::rsmc_pins_t  pin_s3_ff;
	rsmc_pkg::rsmc_pins_t  pin_f_ff;
	rsmc_pkg::rsmc_pins_t  pin_p_ff;
	rsmc_pkg::rsmc_state_t state_ff;
	rsmc_pkg::rsmc_state_t nxt_state;
	logic [7:0]            regs_ff [128];
	logic [2:0]            bit_cnt_ff;
	logic                  first_ff;
	logic                  rw_ff;
	logic [6:0]            addr_ff;
	logic [7:0]            rx_sh_ff;
	logic [7:0]            tx_sh_ff;
	logic [20:0]           tmr_ff;
	logic [20:0]           nxt_tmr;
	logic                  rise_evt;
	logic                  fall_evt;
	logic                  csn_q;
	logic                  sdn_q;
	logic                  byte_done;
	logic [7:0]            byte_in;
	logic                  spi_wr;
	logic                  swres;
	logic [7:0]            mode_reg;
	rsmc_pkg::rsmc_prim_t  prim;
	rsmc_pkg::rsmc_idle_t  idle;

	// Register value after any of the resets
	function automatic logic [7:0] reg_default(input logic [6:0] a);
		if (a == `RSMC_A_MODE) begin
			return `RSMC_RST_MODE;
		end else if (a == `RSMC_A_IEN2) begin
			return `RSMC_RST_IEN2;
		end
		return `RSMC_RST_OTHER;
	endfunction

	// Read view shared by the serial port and the local port
	function automatic logic [7:0] rd_val(input logic [6:0] a, input logic [7:0] r, input logic [1:0] p);
		if (a == `RSMC_A_STATUS) begin
			return {6'h00, p};
		end
		return r;
	endfunction

	// Three stage sampling of pins; second and third must agree to count
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_s1_ff <= '{sclk: 1'b0, sdi: 1'b0, chip_select_n: 1'b1, shutdown_pin: 1'b0};
			pin_s2_ff <= '{sclk: 1'b0, sdi: 1'b0, chip_select_n: 1'b1, shutdown_pin: 1'b0};
			pin_s3_ff <= '{sclk: 1'b0, sdi: 1'b0, chip_select_n: 1'b1, shutdown_pin: 1'b0};
			pin_f_ff  <= '{sclk: 1'b0, sdi: 1'b0, chip_select_n: 1'b1, shutdown_pin: 1'b0};
			pin_p_ff  <= '{sclk: 1'b0, sdi: 1'b0, chip_select_n: 1'b1, shutdown_pin: 1'b0};
		end else if (i_clk_en) begin
			pin_s1_ff <= '{sclk: i_sclk, sdi: i_sdi, chip_select_n: i_chip_select_n, shutdown_pin: i_shutdown_pin};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			pin_f_ff  <= (pin_s2_ff & pin_s3_ff) | (pin_f_ff & (pin_s2_ff ^ pin_s3_ff));
			pin_p_ff  <= pin_f_ff;
		end
	end

	// Edge events on the filtered serial clock
	assign csn_q     = pin_f_ff.chip_select_n;
	assign sdn_q     = pin_f_ff.shutdown_pin;
	assign rise_evt  = pin_f_ff.sclk & ~pin_p_ff.sclk & ~csn_q & ~sdn_q;
	assign fall_evt  = ~pin_f_ff.sclk & pin_p_ff.sclk & ~csn_q & ~sdn_q;
	assign byte_in   = {rx_sh_ff[6:0], pin_f_ff.sdi};
	assign byte_done = rise_evt && (bit_cnt_ff == `RSMC_LAST_BIT);
	// Data byte of a write frame only; read data bits never land
	assign spi_wr    = byte_done && !first_ff && rw_ff;
	assign mode_reg  = regs_ff[`RSMC_A_MODE];
	assign swres     = mode_reg[`RSMC_B_SWRES];

	// Bit counter, frame phase and address
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			bit_cnt_ff <= 3'h0;
			first_ff   <= 1'b1;
			rw_ff      <= 1'b0;
			addr_ff    <= 7'h00;
			rx_sh_ff   <= 8'h00;
		end else if (i_clk_en) begin
			if (csn_q || sdn_q) begin
				// Partial byte dropped; nothing was written for it
				bit_cnt_ff <= 3'h0;
				first_ff   <= 1'b1;
			end else if (rise_evt) begin
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				rx_sh_ff   <= byte_in;
				if (byte_done) begin
					first_ff <= 1'b0;
					if (first_ff) begin
						rw_ff   <= byte_in[`RSMC_RW_BIT];
						addr_ff <= byte_in[6:0];
					end else begin
						addr_ff <= addr_ff + 7'h01;
					end
				end
			end
		end
	end

	// Serial output shifter
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_sh_ff   <= 8'h00;
			o_sdo_out  <= 1'b1;
			o_sdo_oe_n <= 1'b1;
		end else if (i_clk_en) begin
			if (csn_q || sdn_q) begin
				o_sdo_out  <= 1'b1;
				o_sdo_oe_n <= 1'b1;
			end else begin
				o_sdo_oe_n <= 1'b0;
				if (byte_done && first_ff && !byte_in[`RSMC_RW_BIT]) begin
					tx_sh_ff <= rd_val(byte_in[6:0], regs_ff[byte_in[6:0]], prim);
				end else if (byte_done && !first_ff && !rw_ff) begin
					// Burst read fetches the following register
					tx_sh_ff <= rd_val(addr_ff + 7'h01, regs_ff[addr_ff + 7'h01], prim);
				end else if (fall_evt && !first_ff && !rw_ff) begin
					o_sdo_out <= tx_sh_ff[7];
					tx_sh_ff  <= {tx_sh_ff[6:0], tx_sh_ff[0]};
				end
				// No falling edge after the eighth, so D0 simply stays
			end
		end
	end

	// Register space; content lost in shutdown and on soft reset
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 128; i++) begin
				regs_ff[i] <= reg_default(7'(i));
			end
		end else if (i_clk_en) begin
			if (sdn_q || swres) begin
				for (int i = 0; i < 128; i++) begin
					regs_ff[i] <= reg_default(7'(i));
				end
			end else if (spi_wr) begin
				regs_ff[addr_ff] <= byte_in;
			end else if (i_reg_wr) begin
				regs_ff[i_reg_addr] <= i_reg_wdata;
			end
		end
	end

	// Idle mode from the hold bits, highest activity first
	always_comb begin
		if (mode_reg[`RSMC_B_PLLON]) begin
			idle = rsmc_pkg::IDLE_TUNE;
		end else if (mode_reg[`RSMC_B_XTON]) begin
			idle = rsmc_pkg::IDLE_READY;
		end else if (mode_reg[`RSMC_B_ENLBD]) begin
			idle = rsmc_pkg::IDLE_SENSOR;
		end else if (mode_reg[`RSMC_B_ENWT]) begin
			idle = rsmc_pkg::IDLE_SLEEP;
		end else begin
			idle = rsmc_pkg::IDLE_STANDBY;
		end
	end

	// Primary state seen by software
	always_comb begin
		case (state_ff)
			rsmc_pkg::ST_TX:       prim = rsmc_pkg::PRIM_TX;
			rsmc_pkg::ST_RX:       prim = rsmc_pkg::PRIM_RX;
			rsmc_pkg::ST_SHUTDOWN: prim = rsmc_pkg::PRIM_SHUTDOWN;
			rsmc_pkg::ST_POR:      prim = rsmc_pkg::PRIM_SHUTDOWN;
			default:               prim = rsmc_pkg::PRIM_IDLE;
		endcase
	end

	// State sequencing with start-up timers
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr   = (tmr_ff != 21'h0) ? tmr_ff - 21'h1 : 21'h0;
		case (state_ff)
			rsmc_pkg::ST_SHUTDOWN: begin
				if (!sdn_q) begin
					nxt_state = rsmc_pkg::ST_POR;
					nxt_tmr   = 21'(P_SHDN_CYC);
				end
			end
			rsmc_pkg::ST_POR: begin
				if (tmr_ff == 21'h0) begin
					nxt_state = rsmc_pkg::ST_IDLE;
				end
			end
			rsmc_pkg::ST_IDLE: begin
				// Slow path must start the crystal first
				nxt_tmr = (idle == rsmc_pkg::IDLE_READY || idle == rsmc_pkg::IDLE_TUNE) ?
					21'(P_FAST_CYC) : 21'(P_SLOW_CYC);
				if (mode_reg[`RSMC_B_TXON]) begin
					nxt_state = rsmc_pkg::ST_GO_TX;
				end else if (mode_reg[`RSMC_B_RXON]) begin
					nxt_state = rsmc_pkg::ST_GO_RX;
				end
			end
			rsmc_pkg::ST_GO_TX: begin
				if (!mode_reg[`RSMC_B_TXON]) begin
					nxt_state = rsmc_pkg::ST_IDLE;
				end else if (tmr_ff == 21'h0) begin
					nxt_state = rsmc_pkg::ST_TX;
				end
			end
			rsmc_pkg::ST_GO_RX: begin
				if (!mode_reg[`RSMC_B_RXON]) begin
					nxt_state = rsmc_pkg::ST_IDLE;
				end else if (tmr_ff == 21'h0) begin
					nxt_state = rsmc_pkg::ST_RX;
				end
			end
			rsmc_pkg::ST_TX: begin
				nxt_tmr = 21'(P_FAST_CYC);
				if (!mode_reg[`RSMC_B_TXON]) begin
					nxt_state = mode_reg[`RSMC_B_RXON] ? rsmc_pkg::ST_GO_RX : rsmc_pkg::ST_IDLE;
				end
			end
			rsmc_pkg::ST_RX: begin
				nxt_tmr = 21'(P_FAST_CYC);
				if (mode_reg[`RSMC_B_TXON] || !mode_reg[`RSMC_B_RXON]) begin
					nxt_state = mode_reg[`RSMC_B_TXON] ? rsmc_pkg::ST_GO_TX : rsmc_pkg::ST_IDLE;
				end
			end
			default: nxt_state = rsmc_pkg::ST_SHUTDOWN;
		endcase
		if (sdn_q) begin
			nxt_state = rsmc_pkg::ST_SHUTDOWN;
		end
	end

	// State and timer registers; soft reset returns to idle
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= rsmc_pkg::ST_IDLE;
			tmr_ff   <= 21'h0;
		end else if (i_clk_en) begin
			state_ff <= (swres && !sdn_q) ? rsmc_pkg::ST_IDLE : nxt_state;
			tmr_ff   <= nxt_tmr;
		end
	end

	// Registered outputs
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata   <= 8'h00;
			o_radio_state <= 2'h1;
			o_idle_mode   <= 3'h3;
			o_mode_busy   <= 1'b0;
			o_xtal_on     <= 1'b1;
			o_pll_on      <= 1'b0;
			o_wut_on      <= 1'b0;
			o_lbd_on      <= 1'b0;
			o_pa_on       <= 1'b0;
			o_rx_on       <= 1'b0;
		end else if (i_clk_en) begin
			o_reg_rdata   <= i_reg_rd ? rd_val(i_reg_addr, regs_ff[i_reg_addr], prim) : 8'h00;
			o_radio_state <= prim;
			o_idle_mode   <= idle;
			o_mode_busy   <= state_ff == rsmc_pkg::ST_POR || state_ff == rsmc_pkg::ST_GO_TX ||
				state_ff == rsmc_pkg::ST_GO_RX;
			// Tune and any radio state force the crystal on
			o_xtal_on     <= prim != rsmc_pkg::PRIM_SHUTDOWN && state_ff != rsmc_pkg::ST_POR &&
				(mode_reg[`RSMC_B_XTON] || mode_reg[`RSMC_B_PLLON] || state_ff != rsmc_pkg::ST_IDLE);
			o_pll_on      <= prim != rsmc_pkg::PRIM_SHUTDOWN && state_ff != rsmc_pkg::ST_POR &&
				(mode_reg[`RSMC_B_PLLON] || state_ff != rsmc_pkg::ST_IDLE);
			o_wut_on      <= prim != rsmc_pkg::PRIM_SHUTDOWN && mode_reg[`RSMC_B_ENWT];
			o_lbd_on      <= prim != rsmc_pkg::PRIM_SHUTDOWN && mode_reg[`RSMC_B_ENLBD];
			o_pa_on       <= state_ff == rsmc_pkg::ST_TX;
			o_rx_on       <= state_ff == rsmc_pkg::ST_RX;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sdo_release_a: assert property (csn_q && i_clk_en |=> o_sdo_oe_n && o_sdo_out)
		else $error("serial output not released with select high");
	byte_count_a: assert property (byte_done && i_clk_en |=> bit_cnt_ff == 3'h0 && !first_ff)
		else $error("bit counter not wrapped after the eighth clock");
	write_store_a: assert property (spi_wr && i_clk_en && !swres && !sdn_q
		|=> regs_ff[$past(addr_ff)] == $past(byte_in))
		else $error("written byte not stored");
	// Read data phase must leave the addressed register untouched
	read_no_write_a: assert property (byte_done && !first_ff && !rw_ff && !i_reg_wr && !swres && i_clk_en
		|=> regs_ff[$past(addr_ff)] == $past(regs_ff[addr_ff]))
		else $error("read data phase wrote a register");
	burst_incr_a: assert property (byte_done && !first_ff && i_clk_en && !csn_q
		|=> addr_ff == $past(addr_ff) + 7'h01)
		else $error("burst address did not advance");
	sdo_shift_a: assert property (fall_evt && !first_ff && !rw_ff && !byte_done && i_clk_en
		|=> o_sdo_out == $past(tx_sh_ff[7]))
		else $error("read bit not shifted out");
	sdo_hold_a: assert property (!fall_evt && !csn_q && !sdn_q |=> $stable(o_sdo_out))
		else $error("serial output moved without a falling edge");
	shutdown_entry_a: assert property (sdn_q && i_clk_en
		|=> state_ff == rsmc_pkg::ST_SHUTDOWN && regs_ff[`RSMC_A_MODE] == `RSMC_RST_MODE)
		else $error("shutdown not entered or registers kept");
	soft_reset_a: assert property (swres && !sdn_q && i_clk_en
		|=> state_ff == rsmc_pkg::ST_IDLE && regs_ff[`RSMC_A_MODE] == `RSMC_RST_MODE)
		else $error("soft reset did not restore defaults");
	tx_request_a: assert property (i_clk_en && state_ff == rsmc_pkg::ST_IDLE && mode_reg[`RSMC_B_TXON]
		&& !sdn_q && !swres |=> state_ff == rsmc_pkg::ST_GO_TX)
		else $error("transmit request ignored");
	tx_timing_a: assert property ($rose(state_ff == rsmc_pkg::ST_TX) |-> $past(tmr_ff) == 21'h0)
		else $error("TX reached before start-up time");
	abandon_a: assert property (csn_q && i_clk_en |=> bit_cnt_ff == 3'h0 && first_ff)
		else $error("partial frame not abandoned");

	write_seen_c: cover property (spi_wr);
	read_seen_c: cover property (fall_evt && !first_ff && !rw_ff);
	tx_seen_c: cover property ($rose(state_ff == rsmc_pkg::ST_TX));
	rx_seen_c: cover property ($rose(state_ff == rsmc_pkg::ST_RX));

endmodule

`default_nettype wire

//--- bench/rsmc_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host side serial master, mode 0, link clock idle low outside frames
module rsmc_host (
	output logic      o_sclk,
	output logic      o_sdi,
	output logic      o_chip_select_n,
	input  wire logic i_sdo_out,
	input  wire logic i_sdo_oe_n
);
	// Released output floats to the internal pull-up level
	wire sdo_line = i_sdo_oe_n ? 1'b1 : i_sdo_out;

	initial begin
		o_sclk = 1'b0;
		o_sdi = 1'b0;
		o_chip_select_n = 1'b1;
	end

	// Left-aligned bits; more than 16 bits makes a burst
	task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx,
		output logic last_lvl, output logic rel_lvl);
		rx = 24'h000000;
		#20 o_chip_select_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			o_sdi = tx[23-i];
			#62.5 o_sclk = 1'b1;
			rx[23-i] = sdo_line;
			if (i != nbits - 1) begin
				#62.5 o_sclk = 1'b0;
			end
		end
		// Sample the held bit before any further falling edge
		#62.5 last_lvl = sdo_line;
		#50 o_chip_select_n = 1'b1;
		#10 o_sclk = 1'b0;
		// Data line no longer meaningful: drive the inverse
		o_sdi = ~o_sdi;
		#100 rel_lvl = sdo_line;
	endtask
endmodule

`default_nettype wire

//--- bench/tb_radio_spi_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_radio_spi_mode_control;
	localparam int SHDN = 40;
	localparam int SLOW = 20;
	localparam int FAST = 10;

	typedef struct packed {
		logic [7:0] mode;
		logic [2:0] idle;
		logic [3:0] en;
	} rsmc_row_t;

	logic        i_sys_clk      = 1'b0;
	logic        i_rst          = 1'b1;
	logic        i_shutdown_pin = 1'b0;
	logic        i_reg_wr       = 1'b0;
	logic        i_reg_rd       = 1'b0;
	logic [6:0]  i_reg_addr     = 7'h00;
	logic [7:0]  i_reg_wdata    = 8'h00;
	wire         sclk;
	wire         sdi;
	wire         csn;
	logic        sdo_out, sdo_oe_n, busy, xtal, pll, wut, lbd, pa, rxon;
	logic [7:0]  rdata;
	logic [1:0]  state;
	logic [2:0]  idle;
	logic [23:0] rxd;
	logic        last, rel;
	logic [7:0]  rd;
	int          error_cnt   = 0;
	int          check_count = 0;
	int          cyc         = 0;
	// Mode byte, idle mode, enables {xtal, pll, wut, lbd}
	rsmc_row_t   rows [6] = '{'{8'h00, 3'h0, 4'b0000}, '{8'h40, 3'h1, 4'b0010},
		'{8'h60, 3'h2, 4'b0011}, '{8'h01, 3'h3, 4'b1000}, '{8'h02, 3'h4, 4'b1100},
		'{8'h03, 3'h4, 4'b1100}};

	// Free-running system clock
	always #5 i_sys_clk = ~i_sys_clk;

	rsmc_core #(.P_SHDN_CYC(SHDN), .P_SLOW_CYC(SLOW), .P_FAST_CYC(FAST)) rsmc_core_inst (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1), .i_sclk(sclk), .i_sdi(sdi),
		.i_chip_select_n(csn), .i_shutdown_pin(i_shutdown_pin), .o_sdo_out(sdo_out),
		.o_sdo_oe_n(sdo_oe_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata), .o_radio_state(state),
		.o_idle_mode(idle), .o_mode_busy(busy), .o_xtal_on(xtal), .o_pll_on(pll),
		.o_wut_on(wut), .o_lbd_on(lbd), .o_pa_on(pa), .o_rx_on(rxon));

	rsmc_host rsmc_host_inst (
		.o_sclk(sclk), .o_sdi(sdi), .o_chip_select_n(csn),
		.i_sdo_out(sdo_out), .i_sdo_oe_n(sdo_oe_n));

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Bounded wait for a radio state, then compare
	task automatic wait_state(input logic [1:0] exp, input int bound);
		int n;
		n = 0;
		while (state !== exp && n < bound) begin
			@(posedge i_sys_clk);
			n++;
		end
		`CHK(state, exp)
	endtask

	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (6) @(posedge i_sys_clk);
		reg_rd(7'h07, rd);
		`CHK(rd, 8'h01)
		reg_rd(7'h06, rd);
		`CHK(rd, 8'h01)
		`CHK({state, idle, sdo_oe_n, sdo_out}, {2'h1, 3'h3, 2'b11})
		// Interrupt status read once before any low power mode
		reg_rd(7'h03, rd);
		`CHK(rd, 8'h00)
		reg_rd(7'h04, rd);
		`CHK(rd, 8'h00)
		// Buffer override kept clear so ready mode can be left
		reg_wr(7'h62, 8'h00);
		// Every idle mode, written and read back over the serial link
		foreach (rows[i]) begin
			rsmc_host_inst.xfer({1'b1, 7'h07, rows[i].mode, 8'h00}, 16, rxd, last, rel);
			repeat (6) @(posedge i_sys_clk);
			`CHK(idle, rows[i].idle)
			`CHK({xtal, pll, wut, lbd}, rows[i].en)
			reg_rd(7'h07, rd);
			`CHK(rd, rows[i].mode)
			rsmc_host_inst.xfer({1'b0, 7'h07, 8'h00, 8'h00}, 16, rxd, last, rel);
			`CHK(rxd[15:8], rows[i].mode)
			`CHK({last, rel}, {rows[i].mode[0], 1'b1})
		end
		// Top address, burst write, burst read with ones on the input
		rsmc_host_inst.xfer({1'b1, 7'h7f, 8'h5a, 8'h00}, 16, rxd, last, rel);
		reg_rd(7'h7f, rd);
		`CHK(rd, 8'h5a)
		rsmc_host_inst.xfer({1'b1, 7'h10, 8'ha5, 8'h3c}, 24, rxd, last, rel);
		rsmc_host_inst.xfer({1'b0, 7'h10, 8'hff, 8'hff}, 24, rxd, last, rel);
		`CHK(rxd[15:0], 16'ha53c)
		reg_rd(7'h10, rd);
		`CHK(rd, 8'ha5)
		reg_rd(7'h11, rd);
		`CHK(rd, 8'h3c)
		// Select raised after twelve bits: nothing written
		rsmc_host_inst.xfer({1'b1, 7'h12, 8'h77, 8'h00}, 12, rxd, last, rel);
		reg_rd(7'h12, rd);
		`CHK(rd, 8'h00)
		reg_rd(7'h02, rd);
		`CHK(rd, 8'h01)
		// Ready to TX, TX to RX, standby to TX
		reg_wr(7'h07, 8'h09);
		wait_state(2'h2, FAST + 10);
		`CHK(pa, 1'b1)
		reg_wr(7'h07, 8'h05);
		wait_state(2'h3, FAST + 10);
		`CHK(rxon, 1'b1)
		// RX back to TX while both requests are set
		reg_wr(7'h07, 8'h0d);
		wait_state(2'h2, FAST + 10);
		reg_wr(7'h07, 8'h00);
		wait_state(2'h1, 10);
		reg_wr(7'h07, 8'h08);
		wait_state(2'h2, SLOW + 10);
		reg_wr(7'h07, 8'h00);
		// Soft reset restores defaults and ready mode
		reg_wr(7'h07, 8'h80);
		repeat (3) @(posedge i_sys_clk);
		reg_rd(7'h10, rd);
		`CHK({rd, idle}, {8'h00, 3'h3})
		// Shutdown loses registers and blocks serial access
		reg_wr(7'h10, 8'ha5);
		i_shutdown_pin <= 1'b1;
		// Pin filter plus state and output registers take six clocks
		repeat (8) @(posedge i_sys_clk);
		`CHK(state, 2'h0)
		// Serial read in shutdown only sees the pulled-up line
		rsmc_host_inst.xfer({1'b0, 7'h07, 8'h00, 8'h00}, 16, rxd, last, rel);
		`CHK(rxd[15:8], 8'hff)
		@(posedge i_sys_clk);
		i_shutdown_pin <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
		`CHK({busy, state}, {1'b1, 2'h0})
		wait_state(2'h1, SHDN + 20);
		`CHK(idle, 3'h3)
		reg_rd(7'h10, rd);
		`CHK(rd, 8'h00)
		reg_rd(7'h11, rd);
		`CHK(rd, 8'h00)
		finish_test();
	end
endmodule

`default_nettype wire
